// ==== cipv_map.svh ====
// Offsets, field positions, reset values and vector addresses of the priority block.
`ifndef CIPV_MAP_SVH
`define CIPV_MAP_SVH
`define CIPV_OFF_PROMOTE    8'h00
`define CIPV_OFF_ENABLE     8'h04
`define CIPV_OFF_STATUS     8'h08
`define CIPV_PROMOTE_RST    4'h5
`define CIPV_ENABLE_RST     20'h00000
`define CIPV_CODE_RESERVED  4'h5
`define CIPV_CODE_EXT       4'h6
`define CIPV_EN_HANDSHAKE   0
`define CIPV_EN_RECEIVE     1
`define CIPV_EN_IDLE        2
`define CIPV_EN_TX_EMPTY    3
`define CIPV_EN_TX_DONE     4
`define CIPV_EN_SPI         5
`define CIPV_EN_PULSE_EDGE  6
`define CIPV_EN_PULSE_OVF   7
`define CIPV_EN_CNT_OVF     8
`define CIPV_EN_TICK        9
`define CIPV_EN_CAPTURE     10
`define CIPV_EN_COMPARE     13
`define CIPV_EN_WDOG_DIS    18
`define CIPV_EN_CLK_FAIL    19
`define CIPV_VEC_RESET      16'hFFFE
`define CIPV_VEC_CLK_FAIL   16'hFFFC
`define CIPV_VEC_WATCHDOG   16'hFFFA
`define CIPV_VEC_ILLEGAL    16'hFFF8
`define CIPV_VEC_SOFT_TRAP  16'hFFF6
`define CIPV_VEC_PNMI       16'hFFF4
`define CIPV_VEC_EXT        16'hFFF2
`define CIPV_VEC_TICK       16'hFFF0
`define CIPV_VEC_CAPTURE1   16'hFFEE
`define CIPV_VEC_COMPARE1   16'hFFE8
`define CIPV_VEC_CNT_OVF    16'hFFDE
`define CIPV_STACK_LAST     4'h8
`endif

// ==== cipv_pkg.sv ====
// Types shared by the interrupt priority and vectoring block.
package cipv_pkg;
    typedef enum {ST_BOOT, ST_IDLE, ST_STACK, ST_VECTOR} cipv_state_e;
    typedef enum logic [3:0] {
        ITEM_PC_LO, ITEM_PC_HI, ITEM_Y_LO, ITEM_Y_HI, ITEM_X_LO,
        ITEM_X_HI, ITEM_ACCUM_A, ITEM_ACCUM_B, ITEM_FLAGS
    } cipv_item_e;
    // Serial communications causes, each gated by a local enable; rx_full and overrun share the receive enable.
    typedef struct packed {
        logic rx_full;
        logic overrun;
        logic idle_line;
        logic tx_empty;
        logic tx_done;
    } cipv_sci_s;
    // Result of priority resolution.
    typedef struct packed {
        logic        valid;
        logic        pnmi;
        logic [15:0] addr;
    } cipv_pick_s;
endpackage : cipv_pkg

// ==== cipv_irq_ctrl.sv ====
// Interrupt pending, masking, priority resolution, stacking order and vectoring.
//
// Overview of operation
// - Hardware requests stay pending; all but clock fail and watchdog are serviced only at instruction completion.
// - Twenty hardware sources plus one software trap; fifteen masked by maskable flag.
// - Each on-chip maskable source is gated by its local enable and its flags mask.
// - Reset FFFE, clock fail FFFC, watchdog FFFA; these ignore the mask flags.
// - Illegal opcode FFF8, soft trap FFF6 unmaskable; pseudo-NMI pin FFF4.
// - External FFF2, tick FFF0, captures FFEE-FFEA, compares FFE8-FFE0.
// - Counter overflow FFDE down to serial comms FFD6; FFC0-FFD5 reserved.
// - External vector shared by pin and enabled parallel handshake.
// - Serial comms vector shared by five causes with four local enables.
// - Soft trap stacks registers, sets maskable flag, outranks all but clock fail and watchdog.
// - No soft trap fetch while pending; no interrupt until its vector fetched.
// - Illegal opcode detection requests the illegal opcode vector.
// - Entry pushes nine bytes downward; stack pointer ends at SP-9.
// - Reset sets both flags; accepting pseudo-NMI masks it again.
// - Pseudo-NMI flag, once cleared, cannot be set again by a flags transfer; a return can set it.
// - Pseudo-NMI beats all maskable requests; maskable flag never alters it.
// - Maskable entry sets only maskable flag; pseudo-NMI entry sets both.
// - Return restores both flags from the stacked flags byte.
// - Fixed order: reset, clock fail, watchdog, illegal opcode, pseudo-NMI.
// - Software promotes one maskable source to top slot; vector unchanged.
// - Promotion register accepts writes only while maskable flag is set.
// - A promoted source keeps its local enable and maskable flag gating.
// - Select codes 0..15 map sources, code 5 acting as external request.
// - Reset loads select code 5, promoting the external request.
`timescale 1ns/100ps
`include "cipv_map.svh"
module cipv_irq_ctrl
    import cipv_pkg::*;
(
    input  wire logic        SYS_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        EXT_REQ_PIN_N_I,
    input  wire logic        PSEUDO_NMI_PIN_N_I,
    input  wire logic        HANDSHAKE_I,
    input  wire logic        TICK_I,
    input  wire logic [2:0]  CAPTURE_I,
    input  wire logic [4:0]  COMPARE_I,
    input  wire logic        CNT_OVF_I,
    input  wire logic        PULSE_OVF_I,
    input  wire logic        PULSE_EDGE_I,
    input  wire logic        SPI_DONE_I,
    input  wire cipv_sci_s   SCI_I,
    input  wire logic        CLK_FAIL_I,
    input  wire logic        WATCHDOG_FAIL_I,
    input  wire logic        ILLEGAL_OPCODE_I,
    input  wire logic        INSTR_DONE_I,
    input  wire logic        SOFT_TRAP_I,
    input  wire logic [15:0] SP_I,
    input  wire logic        FLAGS_WR_I,
    input  wire logic [1:0]  FLAGS_WDATA_I,
    input  wire logic        RETURN_I,
    input  wire logic [1:0]  RETURN_FLAGS_I,
    input  wire logic        VEC_FETCH_I,
    output logic             SOFT_TRAP_OK_O,
    output logic             STACK_VALID_O,
    output logic      [15:0] STACK_ADDR_O,
    output cipv_item_e       STACK_ITEM_O,
    output logic      [15:0] SP_NEW_O,
    output logic             VECTOR_VALID_O,
    output logic      [15:0] VECTOR_O,
    output logic      [1:0]  FLAGS_O
);

    // Maps a promotion select code to its vector address.
    function automatic logic [15:0] vec_of(input logic [3:0] code);
        logic [15:0] v;
        v = `CIPV_VEC_EXT;
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4:
                v = `CIPV_VEC_CNT_OVF - {11'h000, code, 1'b0};
            4'h5, 4'h6: v = `CIPV_VEC_EXT;
            4'h7: v = `CIPV_VEC_TICK;
            4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF:
                v = `CIPV_VEC_CAPTURE1 - {11'h000, code - 4'h8, 1'b0};
            default: v = `CIPV_VEC_EXT;
        endcase
        return v;
    endfunction : vec_of

    // Fixed maskable priority; codes 6-15 overwrite codes 0-4, lower codes overwriting higher within each group.
    function automatic logic [4:0] fixed_pick(input logic [15:0] req);
        logic [4:0] p;
        p = 5'h00;
        for (int c = 4; c >= 0; c--)
        begin
            if (req[c])
                p = {1'b1, c[3:0]};
        end
        for (int c = 15; c >= 6; c--)
        begin
            if (req[c])
                p = {1'b1, c[3:0]};
        end
        return p;
    endfunction : fixed_pick

    logic        ext_meta;
    logic        ext_sync;
    logic        pnmi_meta;
    logic        pnmi_sync;
    logic [3:0]  promote_sel;
    logic [19:0] enable;
    logic        flag_i;
    logic        flag_x;
    logic        clk_fail_pend;
    logic        wdog_pend;
    logic        illegal_pend;
    cipv_state_e state;
    logic [3:0]  stack_cnt;
    logic        entry_pnmi;
    logic [15:0] entry_vec;
    logic [1:0]  entry_kind;
    logic        sci_any;
    logic [15:0] mask_req;
    logic [3:0]  prom_code;
    logic [4:0]  fixed;
    cipv_pick_s  pick;
    logic        reset_type;
    logic        apb_acc;
    logic        wr_acc;
    logic        addr_ok;
    logic        flags_done;
    logic        serve_done;

    // Two-stage synchronisers for the pin requests, both active low.
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            ext_meta  <= 1'b0;
            ext_sync  <= 1'b0;
            pnmi_meta <= 1'b0;
            pnmi_sync <= 1'b0;
        end
        else
        begin
            ext_meta  <= ~EXT_REQ_PIN_N_I;
            ext_sync  <= ext_meta;
            pnmi_meta <= ~PSEUDO_NMI_PIN_N_I;
            pnmi_sync <= pnmi_meta;
        end
    end

    // Shared serial request and maskable requests indexed by select code.
    always_comb
    begin
        sci_any = (SCI_I.rx_full & enable[`CIPV_EN_RECEIVE])
                | (SCI_I.overrun & enable[`CIPV_EN_RECEIVE])
                | (SCI_I.idle_line & enable[`CIPV_EN_IDLE])
                | (SCI_I.tx_empty & enable[`CIPV_EN_TX_EMPTY])
                | (SCI_I.tx_done & enable[`CIPV_EN_TX_DONE]);
        mask_req[0] = CNT_OVF_I & enable[`CIPV_EN_CNT_OVF];
        mask_req[1] = PULSE_OVF_I & enable[`CIPV_EN_PULSE_OVF];
        mask_req[2] = PULSE_EDGE_I & enable[`CIPV_EN_PULSE_EDGE];
        mask_req[3] = SPI_DONE_I & enable[`CIPV_EN_SPI];
        mask_req[4] = sci_any;
        mask_req[5] = 1'b0;
        mask_req[6] = ext_sync | (HANDSHAKE_I & enable[`CIPV_EN_HANDSHAKE]);
        mask_req[7] = TICK_I & enable[`CIPV_EN_TICK];
        mask_req[10:8] = CAPTURE_I & enable[`CIPV_EN_CAPTURE +: 3];
        mask_req[15:11] = COMPARE_I & enable[`CIPV_EN_COMPARE +: 5];
    end

    // Promotion resolves the reserved code to the external request.
    assign prom_code = (promote_sel == `CIPV_CODE_RESERVED) ? `CIPV_CODE_EXT
                                                            : promote_sel;
    assign fixed = fixed_pick(mask_req);

    // Reset-type sources act at once and obey no flags.
    assign reset_type = clk_fail_pend | wdog_pend;

    // Priority resolution among requests that wait for an instruction boundary.
    always_comb
    begin
        pick = '{valid: 1'b0, pnmi: 1'b0, addr: `CIPV_VEC_EXT};
        if (illegal_pend)
            pick = '{valid: 1'b1, pnmi: 1'b0, addr: `CIPV_VEC_ILLEGAL};
        else if (pnmi_sync && !flag_x)
            pick = '{valid: 1'b1, pnmi: 1'b1, addr: `CIPV_VEC_PNMI};
        else if (!flag_i && mask_req[prom_code])
            pick = '{valid: 1'b1, pnmi: 1'b0, addr: vec_of(prom_code)};
        else if (!flag_i && fixed[4])
            pick = '{valid: 1'b1, pnmi: 1'b0, addr: vec_of(fixed[3:0])};
    end

    // The core may fetch a soft trap only when nothing is pending.
    assign SOFT_TRAP_OK_O = (state == ST_IDLE) && !pick.valid && !reset_type;

    // Sequencer: boot vector, nine-byte stacking, then vector presentation.
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            state        <= ST_BOOT;
            stack_cnt    <= 4'h0;
            entry_pnmi   <= 1'b0;
            entry_vec    <= `CIPV_VEC_RESET;
            entry_kind   <= 2'h0;
            STACK_ADDR_O <= 16'h0000;
            STACK_ITEM_O <= ITEM_PC_LO;
            SP_NEW_O     <= 16'h0000;
            VECTOR_O     <= 16'h0000;
        end
        else
        begin
            case (state)
                ST_BOOT:
                begin
                    VECTOR_O <= `CIPV_VEC_RESET;
                    state    <= ST_VECTOR;
                end
                ST_IDLE:
                begin
                    STACK_ADDR_O <= SP_I;
                    STACK_ITEM_O <= ITEM_PC_LO;
                    SP_NEW_O     <= SP_I - 16'h0009;
                    stack_cnt    <= 4'h0;
                    if (clk_fail_pend)
                    begin
                        VECTOR_O   <= `CIPV_VEC_CLK_FAIL;
                        entry_kind <= 2'h1;
                        state      <= ST_VECTOR;
                    end
                    else if (wdog_pend)
                    begin
                        VECTOR_O   <= `CIPV_VEC_WATCHDOG;
                        entry_kind <= 2'h2;
                        state      <= ST_VECTOR;
                    end
                    else if (SOFT_TRAP_I)
                    begin
                        entry_vec  <= `CIPV_VEC_SOFT_TRAP;
                        entry_pnmi <= 1'b0;
                        entry_kind <= 2'h0;
                        state      <= ST_STACK;
                    end
                    else if (INSTR_DONE_I && pick.valid)
                    begin
                        entry_vec  <= pick.addr;
                        entry_pnmi <= pick.pnmi;
                        entry_kind <= (pick.addr == `CIPV_VEC_ILLEGAL) ? 2'h3 : 2'h0;
                        state      <= ST_STACK;
                    end
                end
                ST_STACK:
                begin
                    stack_cnt    <= stack_cnt + 4'h1;
                    STACK_ADDR_O <= STACK_ADDR_O - 16'h0001;
                    STACK_ITEM_O <= cipv_item_e'(stack_cnt + 4'h1);
                    if (stack_cnt == `CIPV_STACK_LAST)
                    begin
                        VECTOR_O <= entry_vec;
                        state    <= ST_VECTOR;
                    end
                end
                ST_VECTOR:
                begin
                    if (VEC_FETCH_I)
                    begin
                        state <= ST_IDLE;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    assign STACK_VALID_O  = (state == ST_STACK);
    assign VECTOR_VALID_O = (state == ST_VECTOR);
    assign flags_done = (state == ST_STACK) && (stack_cnt == `CIPV_STACK_LAST);
    assign serve_done = (state == ST_VECTOR) && VEC_FETCH_I;

    // Sticky pending latches; a new event in the clearing cycle wins.
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            clk_fail_pend <= 1'b0;
            wdog_pend     <= 1'b0;
            illegal_pend  <= 1'b0;
        end
        else
        begin
            if (CLK_FAIL_I && enable[`CIPV_EN_CLK_FAIL])
                clk_fail_pend <= 1'b1;
            else if (serve_done && entry_kind == 2'h1)
                clk_fail_pend <= 1'b0;
            if (WATCHDOG_FAIL_I && !enable[`CIPV_EN_WDOG_DIS])
                wdog_pend <= 1'b1;
            else if (serve_done && entry_kind == 2'h2)
                wdog_pend <= 1'b0;
            if (ILLEGAL_OPCODE_I)
                illegal_pend <= 1'b1;
            else if (serve_done && entry_kind == 2'h3)
                illegal_pend <= 1'b0;
        end
    end

    // Mask flags: bit 1 is the pseudo-NMI flag, bit 0 the maskable flag.
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            flag_i <= 1'b1;
            flag_x <= 1'b1;
        end
        else if (state == ST_BOOT || (state == ST_IDLE && reset_type))
        begin
            flag_i <= 1'b1;
            flag_x <= 1'b1;
        end
        else if (flags_done)
        begin
            flag_i <= 1'b1;
            flag_x <= flag_x | entry_pnmi;
        end
        else if (RETURN_I)
        begin
            flag_i <= RETURN_FLAGS_I[0];
            flag_x <= RETURN_FLAGS_I[1];
        end
        else if (FLAGS_WR_I)
        begin
            flag_i <= FLAGS_WDATA_I[0];
            flag_x <= flag_x & FLAGS_WDATA_I[1];
        end
    end

    assign FLAGS_O = {flag_x, flag_i};

    // Register bus: zero wait states, error on unmapped offsets.
    assign apb_acc  = PSEL_I && PENABLE_I;
    assign wr_acc   = apb_acc && PWRITE_I;
    assign addr_ok  = (PADDR_I == `CIPV_OFF_PROMOTE) || (PADDR_I == `CIPV_OFF_ENABLE)
                   || (PADDR_I == `CIPV_OFF_STATUS);
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = apb_acc && !addr_ok;

    // Writable registers; promotion only while maskable flag is set.
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            promote_sel <= `CIPV_PROMOTE_RST;
            enable      <= `CIPV_ENABLE_RST;
        end
        else
        begin
            if (wr_acc && PADDR_I == `CIPV_OFF_PROMOTE && flag_i)
                promote_sel <= PWDATA_I[3:0];
            if (wr_acc && PADDR_I == `CIPV_OFF_ENABLE)
                enable <= PWDATA_I[19:0];
        end
    end

    // Read data is registered during the setup cycle.
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            PRDATA_O <= 32'h00000000;
        end
        else if (PSEL_I && !PENABLE_I && !PWRITE_I)
        begin
            case (PADDR_I)
                `CIPV_OFF_PROMOTE: PRDATA_O <= {28'h0000000, promote_sel};
                `CIPV_OFF_ENABLE:  PRDATA_O <= {12'h000, enable};
                `CIPV_OFF_STATUS:  PRDATA_O <= {mask_req, 7'h00, illegal_pend,
                                                wdog_pend, clk_fail_pend,
                                                state == ST_IDLE, pick.valid,
                                                pnmi_sync, ext_sync, flag_x, flag_i};
                default:           PRDATA_O <= 32'h00000000;
            endcase
        end
    end

endmodule : cipv_irq_ctrl

// ==== cipv_irq_ctrl_monitor.sv ====
// Checker of stacking, vectoring and mask flag behaviour at the block ports.
`timescale 1ns/100ps
module cipv_irq_ctrl_monitor
    import cipv_pkg::*;
(
    input  wire logic        SYS_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        INSTR_DONE_I,
    input  wire logic        SOFT_TRAP_I,
    input  wire logic [15:0] SP_I,
    input  wire logic        FLAGS_WR_I,
    input  wire logic        VEC_FETCH_I,
    input  wire logic        STACK_VALID_O,
    input  wire logic [15:0] STACK_ADDR_O,
    input  wire cipv_item_e  STACK_ITEM_O,
    input  wire logic [15:0] SP_NEW_O,
    input  wire logic        VECTOR_VALID_O,
    input  wire logic [15:0] VECTOR_O,
    input  wire logic [1:0]  FLAGS_O
);
    // All checks share the system clock and rest while reset is high.
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    chk_reset_vector: assert property (
        $fell(SYS_RST_I) |=> VECTOR_VALID_O && VECTOR_O == 16'hFFFE)
        else $error("Reset vector not presented.");
    chk_stack_nine: assert property (
        $rose(STACK_VALID_O) |-> STACK_VALID_O[*8] ##1 STACK_VALID_O ##1 !STACK_VALID_O)
        else $error("Stacking did not last nine cycles.");
    chk_stack_first: assert property (
        $rose(STACK_VALID_O) |-> STACK_ADDR_O == SP_I && STACK_ITEM_O == ITEM_PC_LO)
        else $error("First stacked byte wrong.");
    chk_stack_step: assert property (
        STACK_VALID_O && $past(STACK_VALID_O) |-> STACK_ADDR_O == $past(STACK_ADDR_O) - 16'h0001
        && 4'(STACK_ITEM_O) == 4'($past(STACK_ITEM_O)) + 4'h1)
        else $error("Stack order broken.");
    chk_entry_boundary: assert property (
        $rose(STACK_VALID_O) |-> $past(INSTR_DONE_I) || $past(SOFT_TRAP_I))
        else $error("Entry started inside an instruction.");
    chk_sp_final: assert property (
        $fell(STACK_VALID_O) |-> VECTOR_VALID_O && SP_NEW_O == SP_I - 16'h0009)
        else $error("Final stack pointer or vector wrong.");
    chk_vector_hold: assert property (
        VECTOR_VALID_O && !VEC_FETCH_I |=> VECTOR_VALID_O && $stable(VECTOR_O))
        else $error("Vector dropped before fetch.");
    chk_pnmi_flags: assert property (
        $fell(STACK_VALID_O) && VECTOR_O == 16'hFFF4 |-> FLAGS_O == 2'b11)
        else $error("Pseudo-NMI entry flags wrong.");
    chk_mask_flags: assert property (
        $fell(STACK_VALID_O) && VECTOR_O < 16'hFFF4 |-> FLAGS_O[0]
        && FLAGS_O[1] == $past(FLAGS_O[1]))
        else $error("Maskable entry flags wrong.");
    chk_x_sticky: assert property (
        !FLAGS_O[1] && FLAGS_WR_I |=> !FLAGS_O[1])
        else $error("Pseudo-NMI flag set by software.");
endmodule : cipv_irq_ctrl_monitor

// ==== cipv_core_model.sv ====
// Behavioural CPU core that marks instruction ends and fetches vectors.
`timescale 1ns/100ps
module cipv_core_model
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       slow_i,
    input  wire logic       vector_valid_i,
    input  wire logic       stack_valid_i,
    output logic            instr_done_o,
    output logic            vec_fetch_o,
    output logic      [3:0] stack_cnt_o
);
    logic [1:0] div;
    logic [1:0] wait_cnt;

    // Every fourth cycle ends an instruction.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div <= 2'h0;
            instr_done_o <= 1'b0;
        end
        else
        begin
            div <= div + 2'h1;
            instr_done_o <= (div == 2'h3);
        end
    end

    // Fetch the vector at once or after a stall, and count stacked bytes.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wait_cnt <= 2'h0;
            vec_fetch_o <= 1'b0;
            stack_cnt_o <= 4'h0;
        end
        else
        begin
            if (vector_valid_i && !vec_fetch_o)
            begin
                wait_cnt <= wait_cnt + 2'h1;
                vec_fetch_o <= (wait_cnt >= (slow_i ? 2'h2 : 2'h0));
            end
            else
            begin
                wait_cnt <= 2'h0;
                vec_fetch_o <= 1'b0;
            end
            if (vec_fetch_o)
                stack_cnt_o <= 4'h0;
            else if (stack_valid_i)
                stack_cnt_o <= stack_cnt_o + 4'h1;
        end
    end
endmodule : cipv_core_model

// ==== cipv_irq_ctrl_test.sv ====
// Self-checking bench of the interrupt priority and vectoring block.
`timescale 1ns/100ps
module cipv_irq_ctrl_test import cipv_pkg::*;;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  src = 6'h00;
    logic        pnmi_n = 1'b1;
    logic        clk_fail = 1'b0;
    logic        wdog = 1'b0;
    logic        illegal = 1'b0;
    logic        trap = 1'b0;
    logic        fwr = 1'b0;
    logic        ret = 1'b0;
    logic        slow = 1'b0;
    logic [1:0]  fdata = 2'h0;
    logic        instr_done;
    logic        vec_fetch;
    logic        trap_ok;
    logic        stk_v;
    logic        vec_v;
    logic [15:0] vec;
    logic [1:0]  flags;
    logic [3:0]  stk_cnt;
    logic [31:0] rd;
    logic        er;
    int          bad_count = 0;
    int          n_compared = 0;

    // Clock at 200 MHz.
    always #2.5 clk = ~clk;

    cipv_irq_ctrl u_cipv_irq_ctrl (
        .SYS_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_REQ_PIN_N_I(~src[0]),
        .PSEUDO_NMI_PIN_N_I(pnmi_n), .HANDSHAKE_I(1'b0), .TICK_I(src[1]),
        .CAPTURE_I({2'h0, src[5]}), .COMPARE_I({4'h0, src[2]}), .CNT_OVF_I(src[3]),
        .PULSE_OVF_I(1'b0), .PULSE_EDGE_I(1'b0), .SPI_DONE_I(1'b0),
        .SCI_I({src[4], 4'h0}), .CLK_FAIL_I(clk_fail), .WATCHDOG_FAIL_I(wdog),
        .ILLEGAL_OPCODE_I(illegal), .INSTR_DONE_I(instr_done), .SOFT_TRAP_I(trap),
        .SP_I(16'h01FF), .FLAGS_WR_I(fwr), .FLAGS_WDATA_I(fdata), .RETURN_I(ret),
        .RETURN_FLAGS_I(fdata), .VEC_FETCH_I(vec_fetch), .SOFT_TRAP_OK_O(trap_ok),
        .STACK_VALID_O(stk_v), .STACK_ADDR_O(), .STACK_ITEM_O(), .SP_NEW_O(),
        .VECTOR_VALID_O(vec_v), .VECTOR_O(vec), .FLAGS_O(flags));

    cipv_core_model u_cipv_core_model (
        .clk_i(clk), .rst_i(rst), .slow_i(slow), .vector_valid_i(vec_v),
        .stack_valid_i(stk_v), .instr_done_o(instr_done), .vec_fetch_o(vec_fetch),
        .stack_cnt_o(stk_cnt));

    // Compare one result and count it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    // Transfer-to-flags after letting the request lines settle.
    task automatic setf(input logic [1:0] f);
        repeat (4) @(posedge clk);
        fwr <= 1'b1;
        fdata <= f;
        @(posedge clk);
        fwr <= 1'b0;
    endtask : setf

    // Await a vector, check it and the stacked byte count, then let it be fetched.
    task automatic serve(input logic [15:0] exp);
        do
        begin
            @(posedge clk);
            #1;
        end
        while (vec_v !== 1'b1);
        chk(32'(vec), 32'(exp));
        chk(32'(stk_cnt), (exp >= 16'hFFFA) ? 32'h0 : 32'h9);
        while (vec_v !== 1'b0)
        begin
            @(posedge clk);
            #1;
        end
    endtask : serve

    task automatic t_reset;
        serve(16'hFFFE);
        chk(32'(flags), 32'h3);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, 8'h0C, 32'h0);
        chk(32'(er), 32'h1);
        apb(1'b1, 8'h04, 32'h000BFFFF);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_fixed;
        logic [15:0] exp [5] = '{16'hFFF2, 16'hFFF0, 16'hFFE8, 16'hFFDE, 16'hFFD6};
        @(posedge clk);
        src <= 6'h1F;
        for (int k = 0; k < 5; k++)
        begin
            setf(2'b00);
            serve(exp[k]);
            chk(32'(flags), 32'h1);
            @(posedge clk);
            src[k] <= 1'b0;
        end
        $display("t_fixed done");
    endtask : t_fixed

    task automatic t_promote;
        setf(2'b00);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h5);
        setf(2'b01);
        apb(1'b1, 8'h00, 32'h8);
        src <= 6'h21;
        setf(2'b00);
        serve(16'hFFEE);
        apb(1'b1, 8'h04, 32'h000BFBFF);
        setf(2'b00);
        serve(16'hFFF2);
        @(posedge clk);
        src <= 6'h00;
        $display("t_promote done");
    endtask : t_promote

    task automatic t_resets;
        @(posedge clk);
        slow <= 1'b1;
        clk_fail <= 1'b1;
        wdog <= 1'b1;
        illegal <= 1'b1;
        @(posedge clk);
        clk_fail <= 1'b0;
        wdog <= 1'b0;
        illegal <= 1'b0;
        serve(16'hFFFC);
        serve(16'hFFFA);
        serve(16'hFFF8);
        chk(32'(trap_ok), 32'h1);
        @(posedge clk);
        slow <= 1'b0;
        trap <= 1'b1;
        @(posedge clk);
        trap <= 1'b0;
        serve(16'hFFF6);
        chk(32'(flags[0]), 32'h1);
        $display("t_resets done");
    endtask : t_resets

    task automatic t_pnmi;
        @(posedge clk);
        pnmi_n <= 1'b0;
        src <= 6'h02;
        repeat (4) @(posedge clk);
        ret <= 1'b1;
        fdata <= 2'b00;
        @(posedge clk);
        ret <= 1'b0;
        serve(16'hFFF4);
        chk(32'(flags), 32'h3);
        @(posedge clk);
        pnmi_n <= 1'b1;
        src <= 6'h00;
        setf(2'b00);
        setf(2'b11);
        @(posedge clk);
        #1;
        chk(32'(flags), 32'h1);
        $display("t_pnmi done");
    endtask : t_pnmi

    // Print the counts and the verdict, then stop.
    task automatic test_done;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    // Cut a hang short well beyond the expected run length.
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("BAD %0t run did not finish", $time);
        test_done;
    end

    // Main sequence.
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_fixed;
        t_promote;
        t_resets;
        t_pnmi;
        test_done;
    end
endmodule : cipv_irq_ctrl_test

bind cipv_irq_ctrl cipv_irq_ctrl_monitor u_cipv_irq_ctrl_monitor (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .INSTR_DONE_I(INSTR_DONE_I),
    .SOFT_TRAP_I(SOFT_TRAP_I), .SP_I(SP_I), .FLAGS_WR_I(FLAGS_WR_I),
    .VEC_FETCH_I(VEC_FETCH_I), .STACK_VALID_O(STACK_VALID_O),
    .STACK_ADDR_O(STACK_ADDR_O), .STACK_ITEM_O(STACK_ITEM_O), .SP_NEW_O(SP_NEW_O),
    .VECTOR_VALID_O(VECTOR_VALID_O), .VECTOR_O(VECTOR_O), .FLAGS_O(FLAGS_O));
